// file: crs_ahb_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "crs_cfg.svh"

module crs_ahb_regs (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // register contents
    output logic [`CRS_CTRL_W-1:0] ctrl,
    output logic [`CRS_PREHEAT_W-1:0] preheat,
    input wire logic [31:0] status
);
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic [`CRS_CTRL_W-1:0] next_ctrl;
    logic [`CRS_PREHEAT_W-1:0] next_preheat;
    logic [31:0] next_hrdata;
    logic addr_ok;

    // only whole-word transfers are issued, so hsize is not decoded
    assign addr_ok = hsel && hready && htrans[1];

    always_comb begin
        next_wr_pend = 1'b0;
        next_wr_addr = wr_addr;
        next_ctrl = ctrl;
        next_preheat = preheat;
        next_hrdata = hrdata;
        if (wr_pend) begin
            case (wr_addr)
                `CRS_ADDR_CTRL: next_ctrl = hwdata[`CRS_CTRL_W-1:0];
                `CRS_ADDR_PREHEAT: next_preheat = hwdata[`CRS_PREHEAT_W-1:0];
                default: ;
            endcase
        end
        if (addr_ok) begin
            if (hwrite) begin
                next_wr_pend = 1'b1;
                next_wr_addr = haddr[7:0];
            end else begin
                // read data is latched in the address phase: zero wait
                case (haddr[7:0])
                    `CRS_ADDR_CTRL:
                        next_hrdata = {28'h0000000, next_ctrl};
                    `CRS_ADDR_PREHEAT:
                        next_hrdata = {16'h0000, next_preheat};
                    `CRS_ADDR_STATUS: next_hrdata = status;
                    default: next_hrdata = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            ctrl <= `CRS_CTRL_RESET;
            preheat <= `CRS_PREHEAT_RESET;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            ctrl <= next_ctrl;
            preheat <= next_preheat;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// file: crs_cfg.svh
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH

// ----------------------------------------------------------------
// register map (byte addresses, one word each)
// ----------------------------------------------------------------
`define CRS_ADDR_CTRL 8'h00
`define CRS_ADDR_PREHEAT 8'h04
`define CRS_ADDR_STATUS 8'h08

// ----------------------------------------------------------------
// control word fields and reset values
// ----------------------------------------------------------------
`define CRS_CTRL_W 4
`define CRS_CTRL_OXY_BIT 0
`define CRS_CTRL_MODE_LSB 1
`define CRS_CTRL_MODE_MSB 2
`define CRS_CTRL_POL_BIT 3
`define CRS_CTRL_RESET 4'h0
`define CRS_PREHEAT_W 16
`define CRS_PREHEAT_RESET 16'h0000

// ----------------------------------------------------------------
// status word fields
// ----------------------------------------------------------------
`define CRS_ST_STATE_LSB 0
`define CRS_ST_STATE_MSB 5
`define CRS_ST_ENABLE_BIT 8
`define CRS_ST_START_BIT 9
`define CRS_ST_AUX_BIT 10
`define CRS_ST_MOTION_BIT 11
`define CRS_ST_SENSE_BIT 12
`define CRS_ST_HOLD_BIT 13

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CRS_CLK_PERIOD_NS 10
`define CRS_TICK_US 1000
`define CRS_TICK_CYCLES ((`CRS_TICK_US * 1000) / `CRS_CLK_PERIOD_NS)

`endif

// file: crs_pkg.sv
`default_nettype none
package crs_pkg;

    typedef enum logic [5:0] {
        CRS_ST_IDLE    = 6'h01,
        CRS_ST_MOVE    = 6'h02,
        CRS_ST_PIERCE  = 6'h04,
        CRS_ST_PREHEAT = 6'h08,
        CRS_ST_ARMED   = 6'h10,
        CRS_ST_CUT     = 6'h20
    } crs_state_t;

    typedef enum logic [1:0] {
        CRS_MODE_AUTO     = 2'h0,
        CRS_MODE_MANUAL   = 2'h1,
        CRS_MODE_OVERRIDE = 2'h2,
        CRS_MODE_RSVD     = 2'h3
    } crs_mode_t;

endpackage

`default_nettype wire

// file: crs_preheat_timer.sv
`timescale 1ns/100ps
`default_nettype none
`include "crs_cfg.svh"

module crs_preheat_timer #(
    parameter int unsigned TICK_CYCLES = `CRS_TICK_CYCLES,
    parameter int LEN_W = `CRS_PREHEAT_W
) (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // control
    input wire logic start,
    input wire logic [LEN_W-1:0] len,
    // result
    output logic busy,
    output logic done
);
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    logic [31:0] tick, next_tick;
    logic [LEN_W-1:0] left, next_left;
    logic next_busy, next_done;

    // a new start reloads, so an abandoned preheat needs no cancel
    always_comb begin
        next_tick = tick;
        next_left = left;
        next_busy = busy;
        next_done = 1'b0;
        if (start) begin
            next_busy = 1'b1;
            next_left = len;
            next_tick = 32'h00000000;
        end else if (busy) begin
            if (left == '0) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else if (tick == TICK_LAST) begin
                next_tick = 32'h00000000;
                next_left = left - 1'b1;
            end else begin
                next_tick = tick + 32'h00000001;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick <= 32'h00000000;
            left <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            tick <= next_tick;
            left <= next_left;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule

`default_nettype wire

// file: crs_relay_seq.sv
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "crs_cfg.svh"

// How it works
// - auto plasma: start contact closed for the whole cut.
// - manual plasma: start contact always open.
// - override: start contact always open.
// - height-disable idle level set by polarity bit; active is opposite.
// - height-disable active from cut start or corner slowdown until back at speed.
// - override: height-disable held at its idle level.
// - oxy contacts open at reset and, outside override, after recycle.
// - oxy sequences apply whenever the oxy process is selected outside override.
// - manual oxy: enable closes only once sense is off at pierce.
// - motion along path waits for sense on after enabling.
// - manual oxy backup opens oxy contacts, back to pierce wait.
// - path complete opens oxy contacts, back to move-to-pierce.
// - auto oxy: high preheat for set time, then enable and start.
module crs_relay_seq #(
    parameter int unsigned TICK_CYCLES = `CRS_TICK_CYCLES
) (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // motion events, one-cycle pulses
    input wire logic recycle,
    input wire logic cycle_start,
    input wire logic at_pierce,
    input wire logic path_done,
    input wire logic cycle_stop,
    input wire logic backup,
    input wire logic corner_slow,
    input wire logic at_speed,
    // cutting circuit sense (oxy switch or arc on)
    input wire logic sense,
    // relay contacts, high = closed
    output logic enable_contact,
    output logic start_contact,
    output logic aux_contact,
    output logic motion_go
);
    import crs_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [`CRS_CTRL_W-1:0] ctrl;
    logic [`CRS_PREHEAT_W-1:0] preheat;
    logic [31:0] status;
    logic oxy;
    logic height_output_polarity_setting;
    crs_mode_t mode;
    logic is_auto, is_override;

    crs_state_t state, next_state;
    logic height_hold, next_height_hold;
    logic next_enable, next_start, next_aux, next_motion;
    logic tmr_start, tmr_done;
    logic exits;

    crs_ahb_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .ctrl(ctrl),
        .preheat(preheat),
        .status(status)
    );

    assign oxy = ctrl[`CRS_CTRL_OXY_BIT];
    assign height_output_polarity_setting = ctrl[`CRS_CTRL_POL_BIT];
    assign mode = crs_mode_t'(ctrl[`CRS_CTRL_MODE_MSB:`CRS_CTRL_MODE_LSB]);
    // the reserved mode code behaves as manual: the start contact never closes for a plasma cut
    assign is_auto = (mode == CRS_MODE_AUTO);
    assign is_override = (mode == CRS_MODE_OVERRIDE);

    always_comb begin
        status = 32'h00000000;
        status[`CRS_ST_STATE_MSB:`CRS_ST_STATE_LSB] = state;
        status[`CRS_ST_ENABLE_BIT] = enable_contact;
        status[`CRS_ST_START_BIT] = start_contact;
        status[`CRS_ST_AUX_BIT] = aux_contact;
        status[`CRS_ST_MOTION_BIT] = motion_go;
        status[`CRS_ST_SENSE_BIT] = sense;
        status[`CRS_ST_HOLD_BIT] = height_hold;
    end

    // ------------------------------------------------------------
    // preheat timer
    // ------------------------------------------------------------
    assign tmr_start = (next_state == CRS_ST_PREHEAT) &&
                       (state != CRS_ST_PREHEAT);

    crs_preheat_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .LEN_W(`CRS_PREHEAT_W)
    ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .start(tmr_start),
        .len(preheat),
        .busy(),
        .done(tmr_done)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    assign exits = recycle || cycle_stop;

    always_comb begin
        next_state = state;
        if (recycle) begin
            next_state = CRS_ST_IDLE;
        end else if (cycle_stop && (state != CRS_ST_IDLE)) begin
            next_state = CRS_ST_MOVE;
        end else begin
            case (state)
                CRS_ST_IDLE: begin
                    if (cycle_start) begin
                        next_state = CRS_ST_MOVE;
                    end
                end
                CRS_ST_MOVE: begin
                    if (at_pierce) begin
                        next_state = CRS_ST_PIERCE;
                    end
                end
                CRS_ST_PIERCE: begin
                    if (!sense) begin
                        if (oxy && is_auto) begin
                            next_state = CRS_ST_PREHEAT;
                        end else begin
                            next_state = CRS_ST_ARMED;
                        end
                    end
                end
                CRS_ST_PREHEAT: begin
                    if (tmr_done) begin
                        next_state = CRS_ST_ARMED;
                    end
                end
                CRS_ST_ARMED, CRS_ST_CUT: begin
                    if (backup) begin
                        if (oxy && is_auto) begin
                            next_state = CRS_ST_MOVE;
                        end else begin
                            next_state = CRS_ST_PIERCE;
                        end
                    end else if (state == CRS_ST_ARMED) begin
                        if (sense) begin
                            next_state = CRS_ST_CUT;
                        end
                    end else if (path_done) begin
                        next_state = CRS_ST_MOVE;
                    end
                end
                default: next_state = CRS_ST_IDLE;
            endcase
        end
    end

    // corner hold: set wins over the speed-reached clear
    always_comb begin
        next_height_hold = height_hold;
        if (next_state != CRS_ST_CUT) begin
            next_height_hold = 1'b0;
        end else if (state != CRS_ST_CUT) begin
            next_height_hold = 1'b1;
        end else if (corner_slow) begin
            next_height_hold = 1'b1;
        end else if (at_speed) begin
            next_height_hold = 1'b0;
        end
    end

    // contacts follow the state being entered, so they switch with it
    always_comb begin
        next_enable = (next_state == CRS_ST_ARMED) ||
                      (next_state == CRS_ST_CUT);
        next_motion = (next_state == CRS_ST_CUT);
        if (oxy) begin
            next_start = next_enable;
            next_aux = is_auto && (next_state == CRS_ST_PREHEAT);
        end else begin
            next_start = is_auto && next_enable;
            next_aux = height_output_polarity_setting ^ next_height_hold;
        end
        if (is_override) begin
            // machine's own cutting circuit stays in control
            next_enable = 1'b1;
            next_start = 1'b0;
            next_aux = oxy ? 1'b0 : height_output_polarity_setting;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= CRS_ST_IDLE;
            height_hold <= 1'b0;
            enable_contact <= 1'b0;
            start_contact <= 1'b0;
            aux_contact <= 1'b0;
            motion_go <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            height_hold <= next_height_hold;
            enable_contact <= next_enable;
            start_contact <= next_start;
            aux_contact <= next_aux;
            motion_go <= next_motion;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_auto_plasma_start: assert property (
        ce && !oxy && is_auto && !exits && !backup && !path_done &&
        (state == CRS_ST_CUT) |=> start_contact && enable_contact)
        else $error("auto plasma start not closed during cut");

    a_manual_start_open: assert property (
        ce && !oxy && !is_auto && !is_override |=> !start_contact)
        else $error("manual plasma start contact closed");

    a_override_start: assert property (
        ce && is_override |=> !start_contact && enable_contact)
        else $error("override start contact not open");

    a_height_corner: assert property (
        ce && !oxy && !is_override && !exits && !backup && !path_done &&
        (state == CRS_ST_CUT) && corner_slow
        |=> aux_contact != $past(height_output_polarity_setting))
        else $error("height disable not active in corner");

    a_height_speed: assert property (
        ce && !oxy && !is_override && !exits && !backup && !path_done &&
        (state == CRS_ST_CUT) && at_speed && !corner_slow
        |=> aux_contact == $past(height_output_polarity_setting)
            ##1 (!$past(ce) || $past(corner_slow) || $past(oxy) ||
                 aux_contact == $past(height_output_polarity_setting)))
        else $error("height disable active at cutting speed");

    a_override_height: assert property (
        ce && !oxy && is_override
        |=> aux_contact == $past(height_output_polarity_setting))
        else $error("override height output not at idle level");

    a_recycle_open: assert property (
        ce && recycle && oxy && !is_override
        |=> (state == CRS_ST_IDLE) && !enable_contact && !start_contact &&
            !aux_contact)
        else $error("oxy contacts not open after recycle");

    a_pierce_wait: assert property (
        (state == CRS_ST_PIERCE) && sense && !exits
        |=> (state == CRS_ST_PIERCE))
        else $error("left pierce wait with sense on");

    a_motion_hold: assert property (
        (state == CRS_ST_ARMED) && !sense |=> !motion_go)
        else $error("motion began before sense on");

    a_manual_backup: assert property (
        ce && oxy && (mode == CRS_MODE_MANUAL) && backup && !exits &&
        (state == CRS_ST_CUT)
        |=> (state == CRS_ST_PIERCE) && !enable_contact && !start_contact)
        else $error("manual oxy backup did not reopen");

    a_path_done: assert property (
        ce && oxy && !is_override && path_done && !exits && !backup &&
        (state == CRS_ST_CUT)
        |=> (state == CRS_ST_MOVE) && !enable_contact && !start_contact)
        else $error("path done did not open oxy contacts");

    a_preheat_order: assert property (
        ce && oxy && is_auto && !exits && (state == CRS_ST_PIERCE) && !sense
        |=> (state == CRS_ST_PREHEAT) && aux_contact && !enable_contact)
        else $error("preheat did not start first");

    a_preheat_end: assert property (
        ce && oxy && is_auto && !exits && (state == CRS_ST_PREHEAT) &&
        tmr_done
        |=> (state == CRS_ST_ARMED) && !aux_contact && enable_contact &&
            start_contact)
        else $error("preheat end did not enable oxygen");

    a_cycle_stop: assert property (
        ce && cycle_stop && !recycle && (state != CRS_ST_IDLE) && oxy &&
        !is_override
        |=> (state == CRS_ST_MOVE) && !enable_contact && !start_contact &&
            !aux_contact)
        else $error("cycle stop did not open contacts");

    a_auto_backup: assert property (
        ce && oxy && is_auto && backup && !exits && (state == CRS_ST_CUT)
        |=> (state == CRS_ST_MOVE) && !motion_go)
        else $error("auto oxy backup not to move state");

    c_oxy_auto_cut: cover property (
        (state == CRS_ST_PREHEAT) ##[1:1000] (state == CRS_ST_CUT));

    c_plasma_corner: cover property (
        !oxy && (state == CRS_ST_CUT) && corner_slow ##1 height_hold);

    c_backup_pierce: cover property (
        (state == CRS_ST_CUT) ##1 (state == CRS_ST_PIERCE));

    c_override_cut: cover property (is_override && motion_go);
endmodule

`default_nettype wire

// file: crs_torch_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// gas and arc circuit model
// ----------------------------------------------------------------
// gas or arc only flows through a closed enable contact; the start
// contact or the operator's own switch lights it, LAG+1 cycles later
module crs_torch_model #(
    parameter int LAG = 3
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // contacts from the sequencer
    input wire logic enable_contact,
    input wire logic start_contact,
    // bench controls
    input wire logic operator_start,
    input wire logic sense_stuck,
    // sense back to the sequencer
    output logic sense
);
    logic [7:0] lag_line;
    logic [7:0] next_lag_line;
    logic demand;
    always_comb begin
        demand = enable_contact & (start_contact | operator_start);
        next_lag_line = {lag_line[6:0], demand};
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lag_line <= 8'h00;
        end else begin
            lag_line <= next_lag_line;
        end
    end
    // a stuck switch reads on whatever the contacts do
    assign sense = sense_stuck | lag_line[LAG];
endmodule
`default_nettype wire

// file: cut_relay_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "crs_cfg.svh"
module cut_relay_sequencer_tb_top;
    import crs_pkg::*;
    logic hclk;
    logic hresetn;
    logic ce;
    logic hsel;
    logic hwrite;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] rdv;
    logic hreadyout;
    logic hresp;
    logic [7:0] ev;
    logic sense;
    logic op_start;
    logic stuck;
    wire logic [3:0] cont;
    int miscompares;
    int checked;
    crs_relay_seq #(.TICK_CYCLES(4)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .recycle(ev[0]), .cycle_start(ev[1]), .at_pierce(ev[2]),
        .path_done(ev[3]), .cycle_stop(ev[4]), .backup(ev[5]),
        .corner_slow(ev[6]), .at_speed(ev[7]), .sense(sense),
        .enable_contact(cont[3]), .start_contact(cont[2]),
        .aux_contact(cont[1]), .motion_go(cont[0]));
    crs_torch_model #(.LAG(3)) i_torch (
        .hclk(hclk), .hresetn(hresetn), .enable_contact(cont[3]),
        .start_contact(cont[2]), .operator_start(op_start),
        .sense_stuck(stuck), .sense(sense));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cc(input logic [3:0] e);
        chk({28'h0, cont}, {28'h0, e});
    endtask
    // values are read in the edge's active region, before flops update
    task automatic rdy;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rdv = hrdata;
    endtask
    task automatic st(input logic [5:0] s, input logic [3:0] c);
        ahb(1'b0, `CRS_ADDR_STATUS, 32'h0);
        chk({22'h0, rdv[11:8], rdv[5:0]}, {22'h0, c, s});
    endtask
    task automatic pulse(input int i);
        @(posedge hclk);
        ev[i] <= 1'b1;
        @(posedge hclk);
        ev <= 8'h00;
        #1;
    endtask
    task automatic drv(input logic s, input logic o);
        @(posedge hclk);
        stuck <= s;
        op_start <= o;
    endtask
    task automatic wfor(input int b);
        int n;
        n = 0;
        @(posedge hclk);
        #1;
        while (cont[b] !== 1'b1 && n < 200) begin
            @(posedge hclk);
            #1;
            n++;
        end
        chk({31'h0, cont[b]}, 32'h1);
    endtask
    task automatic settle;
        @(posedge hclk);
        #1;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        st(6'h01, 4'h0);
        ahb(1'b0, 8'h0C, 32'h0);
        chk(rdv, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        ahb(1'b0, `CRS_ADDR_CTRL, 32'h0);
        chk(rdv, 32'h0);
        // enable low: a cycle start must not be seen
        ce <= 1'b0;
        pulse(1);
        @(posedge hclk);
        ce <= 1'b1;
        st(6'h01, 4'h0);
    endtask
    task automatic t_oxy_auto;
        ahb(1'b1, `CRS_ADDR_CTRL, 32'h1);
        ahb(1'b1, `CRS_ADDR_PREHEAT, 32'h2);
        ahb(1'b0, `CRS_ADDR_PREHEAT, 32'h0);
        chk(rdv, 32'h2);
        drv(1'b1, 1'b0);
        pulse(1);
        pulse(2);
        st(6'h04, 4'h0);
        drv(1'b0, 1'b0);
        wfor(1);
        cc(4'b0010);
        wfor(3);
        cc(4'b1100);
        wfor(0);
        cc(4'b1101);
        pulse(5);
        cc(4'b0000);
        st(6'h02, 4'h0);
        pulse(2);
        wfor(1);
        pulse(4);
        cc(4'b0000);
        st(6'h02, 4'h0);
    endtask
    task automatic t_oxy_manual;
        ahb(1'b1, `CRS_ADDR_CTRL, 32'h3);
        pulse(2);
        wfor(3);
        cc(4'b1100);
        wfor(0);
        cc(4'b1101);
        drv(1'b1, 1'b0);
        pulse(5);
        cc(4'b0000);
        st(6'h04, 4'h0);
        drv(1'b0, 1'b0);
        wfor(0);
        pulse(3);
        cc(4'b0000);
        st(6'h02, 4'h0);
    endtask
    task automatic t_plasma;
        ahb(1'b1, `CRS_ADDR_CTRL, 32'h0);
        pulse(2);
        wfor(0);
        cc(4'hF);
        pulse(7);
        cc(4'hD);
        pulse(6);
        cc(4'hF);
        pulse(7);
        ahb(1'b1, `CRS_ADDR_CTRL, 32'h8);
        settle();
        cc(4'hF);
        pulse(6);
        cc(4'hD);
        pulse(3);
        cc(4'h2);
        ahb(1'b1, `CRS_ADDR_CTRL, 32'h6);
        pulse(2);
        wfor(3);
        cc(4'h8);
        drv(1'b0, 1'b1);
        wfor(0);
        cc(4'hB);
        pulse(3);
        drv(1'b0, 1'b0);
    endtask
    task automatic t_override;
        ahb(1'b1, `CRS_ADDR_CTRL, 32'hC);
        settle();
        cc(4'hA);
        pulse(2);
        drv(1'b0, 1'b1);
        wfor(0);
        cc(4'hB);
        pulse(6);
        cc(4'hB);
        ahb(1'b1, `CRS_ADDR_CTRL, 32'h1);
        pulse(0);
        cc(4'h0);
        drv(1'b0, 1'b0);
        st(6'h01, 4'h0);
    endtask
    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        ev = 8'h00;
        op_start = 1'b0;
        stuck = 1'b0;
        miscompares = 0;
        checked = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_oxy_auto();
        t_oxy_manual();
        t_plasma();
        t_override();
        print_verdict();
    end
    // whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
